/* File: dv/serial_host.sv */
`timescale 1ns/10ps
// ==========================================================
// serial host: link clock runs only inside the clocks task, with chip select low or high
module serial_host #(
    parameter int HALF = 80
) (
    // link pins
    output logic            serial_clock,
    output logic            cs_n,
    output logic            din,
    input  wire logic       dout,
    input  wire logic       busy,
    // front end state looked at in mid-conversion
    input  wire logic [2:0] mid_in
);
    logic [63:0] tx_q;
    logic [63:0] rx_q;
    logic [63:0] busy_q;
    logic [2:0]  mid_q;
    int          k;

    initial begin
        serial_clock = 1'h0;
        cs_n         = 1'h1;
        din          = 1'h0;
        tx_q         = '0;
        rx_q         = '0;
        busy_q       = '0;
        mid_q        = '0;
        k            = 0;
    end

    task automatic select(input logic [63:0] words);
        tx_q   = words;
        rx_q   = '0;
        busy_q = '0;
        k      = 0;
        cs_n   = 1'h0;
        #(HALF);
    endtask

    task automatic deselect;
        cs_n = 1'h1;
    endtask

    // n clocks, optionally split into bursts of eight with a pause between
    task automatic clocks(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            if (gap != 0 && i != 0 && i % 8 == 0) begin
                #(gap);
            end
            din  = tx_q[63];
            tx_q = tx_q << 1;
            #(HALF);
            k++;
            rx_q   = {rx_q[62:0], dout};
            busy_q = {busy_q[62:0], busy};
            if (k == 15) begin
                mid_q = mid_in;
            end
            serial_clock = 1'h1;
            #(HALF);
            serial_clock = 1'h0;
        end
        din = 1'h0;
    endtask
endmodule

/* File: dv/test_touch_adc_serial_sequencer.sv */
`timescale 1ns/10ps
module test_touch_adc_serial_sequencer;
    import touch_pkg::*;

    logic                clk;
    logic                resetn;
    logic [RESULT_W-1:0] sample_value;
    logic                conv_done;
    logic                serial_clock;
    logic                cs_n;
    logic                din;
    logic                dout;
    logic                dout_oe_n;
    logic                busy;
    logic                busy_oe_n;
    logic                y_plate_drive;
    logic                x_plate_drive;
    logic                y_minus_switch;
    logic                track_hold;
    logic                adc_power;
    logic                ref_power;
    int                  error_cnt;
    int                  cmp_count;
    int                  done_cnt;

    always #12.5 clk = ~clk;

    touch_adc_serial_sequencer uut (
        .clk            (clk),
        .resetn         (resetn),
        .sample_value   (sample_value),
        .conv_done      (conv_done),
        .serial_clock   (serial_clock),
        .cs_n           (cs_n),
        .din            (din),
        .dout           (dout),
        .dout_oe_n      (dout_oe_n),
        .busy           (busy),
        .busy_oe_n      (busy_oe_n),
        .y_plate_drive  (y_plate_drive),
        .x_plate_drive  (x_plate_drive),
        .y_minus_switch (y_minus_switch),
        .track_hold     (track_hold),
        .adc_power      (adc_power),
        .ref_power      (ref_power)
    );

    serial_host host (
        .serial_clock (serial_clock),
        .cs_n         (cs_n),
        .din          (din),
        .dout         (dout),
        .busy         (busy),
        .mid_in       ({x_plate_drive, adc_power, track_hold})
    );

    always @(posedge clk) begin
        if (conv_done === 1'h1) begin
            done_cnt++;
        end
    end

    // ==========================================================
    // checking and closing
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // two conversions, second word starting p clocks after the first
    task automatic run_case(input int p, input logic r8, input logic [2:0] ch2,
                            input logic [1:0] pd2, input int gap);
        logic [7:0]  w1;
        logic [7:0]  w2;
        logic [11:0] s1;
        logic [11:0] s2;
        logic [63:0] rx;
        int          d0;
        w1 = {1'h1, CH_X_DRIVE, r8, 1'h0, 2'h0};
        w2 = {1'h1, ch2, r8, 1'h0, pd2};
        s1 = 12'hA5C + 12'(p);
        s2 = 12'h3C6 - 12'(p);
        @(negedge clk) sample_value = s1;
        repeat (60) @(negedge clk);
        d0 = done_cnt;
        host.select({w1, 56'h0} | ({w2, 56'h0} >> p));
        host.clocks(p, gap);
        @(negedge clk) sample_value = s2;
        // pause mid-frame with the link clock stopped
        repeat (60) @(negedge clk);
        host.clocks(24, 0);
        rx = host.rx_q;
        check("oe in frame", 64'({dout_oe_n, busy_oe_n}), 64'h0);
        // in 8-bit with 11-clock framing the next result starts three clocks after the 8 data bits
        check("result one", (rx >> (p + 3)) & (r8 ? 64'hFF0 : 64'hFFF),
              64'(r8 ? {s1[11:4], 4'h0} : s1));
        check("result two", 64'(rx[14:0]), 64'({(r8 ? {s2[11:4], 4'h0} : s2), 3'h0}));
        check("busy", host.busy_q, (64'h1 << (p + 15)) | (64'h1 << 15));
        check("mid conversion", 64'(host.mid_q), 64'h7);
        check("plates", 64'({y_plate_drive, x_plate_drive, y_minus_switch}),
              64'(pd2 == PD_ALL_ON ? {ch2 == CH_Y_DRIVE, ch2 == CH_X_DRIVE, 1'h0} : 3'h1));
        check("power", 64'({adc_power, ref_power}), 64'({pd2[0], pd2[1]}));
        host.deselect();
        #10;
        check("deselect", 64'({dout_oe_n, busy_oe_n, busy, y_plate_drive, x_plate_drive,
              y_minus_switch}), 64'h31);
        repeat (20) @(negedge clk);
        check("conversions", 64'(done_cnt - d0), 64'h2);
    endtask

    // ==========================================================
    // main sequence
    int         per [5] = '{24, 16, 15, 24, 11};
    logic       res [5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
    logic [2:0] chs [5] = '{CH_Y_DRIVE, CH_X_DRIVE, CH_Y_DRIVE, CH_X_DRIVE, CH_Y_DRIVE};
    logic [1:0] pds [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};

    initial begin
        clk          = 1'h0;
        resetn       = 1'h0;
        sample_value = '0;
        error_cnt    = 0;
        cmp_count    = 0;
        done_cnt     = 0;
        // link side reset needs serial edges, chip select stays high
        host.clocks(4, 0);
        @(negedge clk) resetn = 1'h1;
        host.clocks(3, 0);
        repeat (4) @(negedge clk);
        check("idle pins", 64'({dout_oe_n, busy_oe_n, y_minus_switch}), 64'h7);
        for (int c = 0; c < 5; c++) begin
            run_case(per[c], res[c], chs[c], pds[c], (per[c] == 24) ? 500 : 0);
        end
        finish_test;
    end

    initial begin
        for (int i = 0; i < 100000; i++) begin
            @(posedge clk);
        end
        error_cnt++;
        finish_test;
    end
endmodule

/* File: inc/touch_pkg.sv */
package touch_pkg;

    // ==========================================================
    // control word layout, sent most significant bit first
    typedef struct packed {
        logic       start;
        logic [2:0] channel;
        logic       res8;
        logic       ref_single;
        logic [1:0] pd;
    } ctrl_word_type;

    localparam int unsigned CTRL_BITS   = 8;
    localparam int unsigned START_POS   = 7;
    localparam int unsigned CH_MSB      = 6;
    localparam int unsigned CH_LSB      = 4;
    localparam int unsigned RES_POS     = 3;
    localparam int unsigned REF_POS     = 2;
    localparam int unsigned PD1_POS     = 1;
    localparam int unsigned PD0_POS     = 0;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;

    // ==========================================================
    // frame counts, in serial clocks
    localparam int unsigned FRAME_CLOCKS = 24;
    localparam int unsigned ACQ_CLOCKS   = 3;
    localparam int unsigned TRAIL_ZEROS  = 3;
    localparam logic [2:0]  RX_LAST      = 3'h7;
    localparam logic [2:0]  ACQ_FIRST    = 3'h4;
    localparam logic [2:0]  ACQ_LAST     = 3'h6;
    localparam logic [2:0]  PD1_CNT      = 3'h6;
    localparam logic [3:0]  BITS_12      = 4'hC;
    localparam logic [3:0]  BITS_8       = 4'h8;
    localparam int unsigned RESULT_W     = 12;

    // ==========================================================
    // channel and power codes
    localparam logic [2:0] CH_Y_DRIVE = 3'h1;
    localparam logic [2:0] CH_X_DRIVE = 3'h5;
    localparam logic [1:0] PD_ALL_ON  = 2'h3;

    typedef struct packed {
        logic y_drv;
        logic x_drv;
        logic y_minus;
    } plate_type;

    localparam plate_type PLATE_IDLE = 3'h1;

    typedef enum logic {
        RX_IDLE = 1'b0,
        RX_WORD = 1'b1
    } rx_state_type;

endpackage

/* File: rtl/toggle_sync.sv */
`timescale 1ns/10ps
module toggle_sync (
    // clock and reset of the receiving domain
    input  wire logic clk,
    input  wire logic resetn,
    // toggle from the other domain
    input  wire logic toggle,
    // synchronised level and one-cycle pulse on each change
    output logic      level,
    output logic      pulse
);
    logic s1_q, s2_q, s3_q;
    logic s1_d, s2_d, s3_d;

    always_comb begin
        s1_d = resetn ? toggle : 1'b0;
        s2_d = resetn ? s1_q : 1'b0;
        s3_d = resetn ? s2_q : 1'b0;
    end

    always_ff @(posedge clk) begin
        s1_q <= s1_d;
        s2_q <= s2_d;
        s3_q <= s3_d;
    end

    assign level = s2_q;
    assign pulse = s2_q ^ s3_q;
endmodule

/* File: rtl/touch_adc_serial_sequencer.sv */
`timescale 1ns/10ps
// Notes on behaviour
// R01 - serial clock shifts data and runs conversion
// R02 - basic frame fits in 24 serial clocks
// R03 - chip select low enables busy and data
// R04 - eight control bits, settings updated per bit
// R05 - three acquisition clocks, then power bits apply
// R06 - conversion start: hold, busy high one clock
// R07 - single-ended modes open switches at conversion
// R08 - twelve clocks convert and shift result out
// R09 - ratiometric keeps plate switches closed while converting
// R10 - host gives thirteenth clock for the LSB
// R11 - three trailing zeros complete the frame
// R12 - clocks may come continuously or in bursts
// R13 - code 001 drives Y, 101 drives X
// R14 - power codes 00/01/10: Y-minus on at end
// R15 - code 11 keeps drivers until settings change; chip select high also resets them to idle
// R16 - overlapped control words give 16-clock conversions
// R17 - stays powered during pauses between bytes
// R18 - fastest framing: 12 convert plus 3 acquire
// R19 - resolution bit one selects 8-bit conversion
// R20 - 8-bit conversion ends four clocks sooner
// R21 - 8-bit allows two conversions per 24 clocks
// R22 - first high input bit starts control word
// R23 - word: start, channel, resolution, reference, power
// R24 - resolution bit zero selects 12-bit conversion
// R25 - power code sets ADC and reference power
// R26 - result MSB first, changed on falling edges
module touch_adc_serial_sequencer
    import touch_pkg::*;
(
    // system clock domain
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic [RESULT_W-1:0] sample_value,
    output logic                     conv_done,
    // serial link
    input  wire logic                serial_clock,
    input  wire logic                cs_n,
    input  wire logic                din,
    output logic                     dout,
    output logic                     dout_oe_n,
    output logic                     busy,
    output logic                     busy_oe_n,
    // analog front end control
    output logic                     y_plate_drive,
    output logic                     x_plate_drive,
    output logic                     y_minus_switch,
    output logic                     track_hold,
    output logic                     adc_power,
    output logic                     ref_power
);
    // ==========================================================
    // system side: offers samples by a toggle handshake
    logic                req_q, req_d;
    logic [RESULT_W-1:0] xfer_q, xfer_d;
    logic                done_q, done_d;
    logic                ack_level, conv_pulse;
    logic                ack_q, conv_tog_q;

    toggle_sync u_ack_sync (
        .clk    (clk),
        .resetn (resetn),
        .toggle (ack_q),
        .level  (ack_level),
        .pulse  ()
    );

    toggle_sync u_conv_sync (
        .clk    (clk),
        .resetn (resetn),
        .toggle (conv_tog_q),
        .level  (),
        .pulse  (conv_pulse)
    );

    always_comb begin
        req_d  = req_q;
        xfer_d = xfer_q;
        done_d = conv_pulse;
        if (!resetn) begin
            req_d  = 1'b0;
            xfer_d = '0;
            done_d = 1'b0;
        end else if (ack_level == req_q) begin
            // word only changes once the link side has taken it
            xfer_d = sample_value;
            req_d  = ~req_q;
        end
    end

    always_ff @(posedge clk) begin
        req_q  <= req_d;
        xfer_q <= xfer_d;
        done_q <= done_d;
    end

    assign conv_done = done_q;

    // ==========================================================
    // link side, rising edges: reset sync, word receive
    logic                link_rst1_q, link_rst_n_q;
    logic                req_level;
    rx_state_type        rx_state_q, rx_state_d;
    logic [2:0]          rx_cnt_q, rx_cnt_d;
    ctrl_word_type       ctrl_q, ctrl_d;
    logic                acq_q, acq_d;
    logic                word_done_q, word_done_d;
    logic                ref_on_q, ref_on_d;
    logic                ack_d;
    logic [RESULT_W-1:0] word_q, word_d;

    toggle_sync u_req_sync (
        .clk    (serial_clock),
        .resetn (link_rst_n_q),
        .toggle (req_q),
        .level  (req_level),
        .pulse  ()
    );

    always_ff @(posedge serial_clock) begin
        link_rst1_q  <= resetn;
        link_rst_n_q <= link_rst1_q;
    end

    always_comb begin
        rx_state_d  = rx_state_q;
        rx_cnt_d    = rx_cnt_q;
        ctrl_d      = ctrl_q;
        ref_on_d    = ref_on_q;
        word_done_d = 1'b0;
        ack_d       = ack_q;
        word_d      = word_q;
        acq_d       = (rx_state_q == RX_WORD) && (rx_cnt_q >= ACQ_FIRST)
                      && (rx_cnt_q <= ACQ_LAST);                          // [R05]
        if (req_level != ack_q) begin
            word_d = xfer_q;
            ack_d  = req_level;
        end
        if (!link_rst_n_q) begin
            rx_state_d = RX_IDLE;
            rx_cnt_d   = 3'h0;
            ctrl_d     = CTRL_RESET;
            ref_on_d   = 1'b0;
            acq_d      = 1'b0;
            ack_d      = 1'b0;
            word_d     = '0;
        end else if (cs_n) begin
            rx_state_d = RX_IDLE;
            rx_cnt_d   = 3'h0;
            acq_d      = 1'b0;
        end else begin
            unique case (rx_state_q)
                RX_IDLE: begin
                    // a word may start while the last result shifts out
                    if (din) begin                                        // [R22] [R16] [R18]
                        rx_state_d   = RX_WORD;
                        rx_cnt_d     = 3'h1;
                        ctrl_d.start = 1'b1;
                    end
                end
                RX_WORD: begin
                    ctrl_d[RX_LAST - rx_cnt_q] = din;                    // [R04] [R23]
                    rx_cnt_d = rx_cnt_q + 3'h1;
                    if (rx_cnt_q == PD1_CNT) begin
                        ref_on_d = din;                                   // [R25]
                    end
                    if (rx_cnt_q == RX_LAST) begin
                        word_done_d = 1'b1;                               // [R05]
                        rx_state_d  = RX_IDLE;
                        rx_cnt_d    = 3'h0;
                    end
                end
            endcase
        end
    end

    // state holds while the clock stops between bursts
    always_ff @(posedge serial_clock) begin                               // [R01] [R12] [R17]
        rx_state_q  <= rx_state_d;
        rx_cnt_q    <= rx_cnt_d;
        ctrl_q      <= ctrl_d;
        acq_q       <= acq_d;
        word_done_q <= word_done_d;
        ref_on_q    <= ref_on_d;
        ack_q       <= ack_d;
        word_q      <= word_d;
    end

    // ==========================================================
    // link side, falling edges: conversion, result, plates
    logic                busy_q, busy_d;
    logic                hold_q, hold_d;
    logic                dout_q, dout_d;
    logic                oe_n_q, oe_n_d;
    logic [RESULT_W-1:0] out_sr_q, out_sr_d;
    logic [3:0]          left_q, left_d;
    plate_type           plate_q, plate_d;
    logic                conv_start, conv_end;
    logic [1:0]          conv_pd_q, conv_pd_d;

    always_comb begin
        busy_d     = 1'b0;
        hold_d     = hold_q;
        dout_d     = 1'b0;
        oe_n_d     = 1'b0;                                                // [R03]
        out_sr_d   = out_sr_q;
        left_d     = left_q;
        plate_d    = plate_q;
        conv_start = 1'b0;
        conv_end   = 1'b0;
        if (acq_q && !hold_q) begin
            plate_d.y_drv   = (ctrl_q.channel == CH_Y_DRIVE);            // [R13]
            plate_d.x_drv   = (ctrl_q.channel == CH_X_DRIVE);            // [R13]
            plate_d.y_minus = 1'b0;
        end
        if (word_done_q) begin
            conv_start = 1'b1;
            busy_d     = 1'b1;                                            // [R06]
            hold_d     = 1'b1;                                            // [R06]
            out_sr_d   = word_q;
            left_d     = ctrl_q.res8 ? BITS_8 : BITS_12;                  // [R19] [R24] [R20]
            if (ctrl_q.ref_single) begin                                  // [R09]
                plate_d.y_drv = 1'b0;                                     // [R07]
                plate_d.x_drv = 1'b0;                                     // [R07]
            end
        end else if (left_q != 4'h0) begin
            dout_d   = out_sr_q[RESULT_W-1];                              // [R26] [R08]
            out_sr_d = {out_sr_q[RESULT_W-2:0], 1'b0};
            left_d   = left_q - 4'h1;
            if (left_q == 4'h1) begin                                     // [R02] [R21]
                conv_end = 1'b1;
                hold_d   = 1'b0;
                if (conv_pd_q != PD_ALL_ON) begin
                    plate_d = PLATE_IDLE;                                 // [R14]
                end
            end
        end
        if (!link_rst_n_q) begin
            hold_d   = 1'b0;
            oe_n_d   = 1'b1;
            out_sr_d = '0;
            left_d   = 4'h0;
            plate_d  = PLATE_IDLE;
        end
    end

    // chip select high ends the frame without a clock edge
    always_ff @(negedge serial_clock or posedge cs_n) begin
        if (cs_n) begin
            busy_q   <= 1'b0;
            hold_q   <= 1'b0;
            dout_q   <= 1'b0;
            oe_n_q   <= 1'b1;                                             // [R03]
            out_sr_q <= '0;
            left_q   <= 4'h0;
            plate_q  <= PLATE_IDLE;                                       // [R15]
        end else begin
            busy_q   <= busy_d;
            hold_q   <= hold_d;
            dout_q   <= dout_d;                                           // [R11]
            oe_n_q   <= oe_n_d;
            out_sr_q <= out_sr_d;
            left_q   <= left_d;
            plate_q  <= plate_d;
        end
    end

    // power and event state kept across frames
    logic       adc_on_q, adc_on_d;
    logic       conv_tog_d;

    always_comb begin
        adc_on_d   = adc_on_q;
        conv_tog_d = conv_tog_q;
        conv_pd_d  = conv_pd_q;
        if (!link_rst_n_q) begin
            adc_on_d   = 1'b0;
            conv_tog_d = 1'b0;
            conv_pd_d  = 2'h0;
        end else if (conv_start) begin
            adc_on_d   = 1'b1;                                            // [R25]
            conv_tog_d = ~conv_tog_q;
            conv_pd_d  = ctrl_q.pd;                                       // [R05]
        end else if (conv_end) begin
            adc_on_d = conv_pd_q[PD0_POS];                                // [R25]
        end
    end

    always_ff @(negedge serial_clock) begin
        adc_on_q   <= adc_on_d;
        conv_tog_q <= conv_tog_d;
        conv_pd_q  <= conv_pd_d;
    end

    assign dout           = dout_q;
    assign dout_oe_n      = oe_n_q;
    assign busy           = busy_q;
    assign busy_oe_n      = oe_n_q;
    assign y_plate_drive  = plate_q.y_drv;
    assign x_plate_drive  = plate_q.x_drv;
    assign y_minus_switch = plate_q.y_minus;
    assign track_hold     = hold_q;
    assign adc_power      = adc_on_q;
    assign ref_power      = ref_on_q;

    // ==========================================================
    // checks
    property p_word_eight;
        @(posedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        (rx_state_q == RX_IDLE && din) |-> ##8 word_done_q;
    endproperty
    a_word_eight: assert property (p_word_eight) else $error("word not done in 8"); // [R04]

    property p_acq_three;
        @(posedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        $rose(acq_q) |-> acq_q [*3] ##1 !acq_q;
    endproperty
    a_acq_three: assert property (p_acq_three) else $error("acquire not 3 clocks"); // [R05]

    property p_busy_pulse;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        word_done_q |=> busy_q && hold_q ##1 !busy_q;
    endproperty
    a_busy_pulse: assert property (p_busy_pulse) else $error("busy not one clock"); // [R06]

    property p_conv_12;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        (word_done_q && !ctrl_q.res8) |-> ##12 hold_q ##1 !hold_q;
    endproperty
    a_conv_12: assert property (p_conv_12) else $error("12-bit length wrong"); // [R08]

    property p_conv_8;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        (word_done_q && ctrl_q.res8) |-> ##8 hold_q ##1 !hold_q;
    endproperty
    a_conv_8: assert property (p_conv_8) else $error("8-bit length wrong"); // [R20]

    property p_msb_first;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        busy_q |=> dout_q == $past(out_sr_q[RESULT_W-1]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("MSB not first"); // [R26]

    property p_trail_zero;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        $fell(hold_q) |=> !dout_q [*3];
    endproperty
    a_trail_zero: assert property (p_trail_zero) else $error("trailing bit not 0"); // [R11]

    property p_plate_sel;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        (acq_q && !hold_q && ctrl_q.channel == CH_X_DRIVE) |=> plate_q.x_drv && !plate_q.y_drv;
    endproperty
    a_plate_sel: assert property (p_plate_sel) else $error("X drivers not on"); // [R13]

    property p_ratio_closed;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        (word_done_q && !ctrl_q.ref_single && plate_q.y_drv) |=> plate_q.y_drv;
    endproperty
    a_ratio_closed: assert property (p_ratio_closed) else $error("switch opened"); // [R09]

    property p_yminus_end;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        (conv_end && conv_pd_q != PD_ALL_ON) |=> plate_q.y_minus && !plate_q.x_drv;
    endproperty
    a_yminus_end: assert property (p_yminus_end) else $error("Y-minus not on"); // [R14]

    property p_keep_on;
        @(negedge serial_clock) disable iff (!link_rst_n_q || cs_n)
        (conv_end && conv_pd_q == PD_ALL_ON && plate_q.x_drv) |=> plate_q.x_drv;
    endproperty
    a_keep_on: assert property (p_keep_on) else $error("drivers dropped"); // [R15]

    c_conv_12: cover property (@(negedge serial_clock) conv_end && !ctrl_q.res8);
    c_conv_8: cover property (@(negedge serial_clock) conv_end && ctrl_q.res8);
    c_overlap: cover property (@(posedge serial_clock) rx_state_q == RX_WORD && hold_q);
endmodule
